// ==== hdl/wpr_pkg.sv ====
// Constants shared by the register write protection block.
package wpr_pkg;

	// Avalon-MM slave geometry, byte addressed, one 32-bit word per register.
	localparam int WPR_ADDR_W = 8;
	localparam int WPR_DATA_W = 32;
	localparam int WPR_BE_W = 4;

	// Register map.
	localparam logic [7:0] WPR_ADDR_CTRL = 8'h00;
	localparam logic [7:0] WPR_ADDR_CLK_BASE = 8'h10;
	localparam logic [7:0] WPR_ADDR_MODE_BASE = 8'h20;
	localparam logic [7:0] WPR_ADDR_VMON_BASE = 8'h30;

	// Words held by each protected group, and the software reset word in the mode group.
	localparam logic [2:0] WPR_CLK_WORDS = 3'h4;
	localparam logic [2:0] WPR_MODE_WORDS = 3'h4;
	localparam logic [2:0] WPR_VMON_WORDS = 3'h2;
	localparam logic [1:0] WPR_SWRST_IDX = 2'h3;

	// Field layout of write_protect_control.
	localparam int WPR_KEY_LSB = 8;
	localparam int WPR_KEY_MSB = 15;
	localparam int WPR_LOCK_CLK_BIT = 0;
	localparam int WPR_LOCK_MODE_BIT = 1;
	localparam int WPR_LOCK_VMON_BIT = 3;
	localparam logic [7:0] WPR_UNLOCK_KEY = 8'hA5;
	localparam logic [15:0] WPR_UNLOCK_ALL = 16'hA50B;
	localparam logic [15:0] WPR_LOCK_ALL = 16'hA500;

	// Reset values.
	localparam logic WPR_LOCK_RESET = 1'b0;
	localparam logic [31:0] WPR_REG_RESET = 32'h0000_0000;
	localparam logic [31:0] WPR_UNMAPPED_READ = 32'h0000_0000;

endpackage : wpr_pkg

// ==== hdl/wpr_avalon_slave.sv ====
// Avalon-MM handshake with one wait cycle and registered read data.
`timescale 1ns/1ns
module wpr_avalon_slave (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_b,
	// Bus request.
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [wpr_pkg::WPR_DATA_W-1:0] rdWord,
	// Bus answer.
	output logic avs_waitrequest,
	output logic [wpr_pkg::WPR_DATA_W-1:0] avs_readdata,
	output logic accept
);
	import wpr_pkg::*;

	logic waitReq_q;
	logic [WPR_DATA_W-1:0] readData_q;

	// Read data is captured a cycle early so that it stands at the accepting edge.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			waitReq_q <= 1'b1;
		end else if (waitReq_q && (avs_read || avs_write)) begin
			waitReq_q <= 1'b0;
		end else if (!waitReq_q) begin
			waitReq_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			readData_q <= WPR_REG_RESET;
		end else if (waitReq_q && avs_read) begin
			readData_q <= rdWord;
		end
	end

	assign avs_waitrequest = waitReq_q;
	assign avs_readdata = readData_q;
	assign accept = !waitReq_q && (avs_read || avs_write);

endmodule : wpr_avalon_slave

// ==== hdl/wpr_prot_bank.sv ====
// One group of protected registers that accepts writes only while unlocked.
`timescale 1ns/1ns
module wpr_prot_bank #(
	parameter int WORDS = 4
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_b,
	// Write port.
	input wire logic writeEn,
	input wire logic unlock,
	input wire logic [1:0] wordIdx,
	input wire logic [wpr_pkg::WPR_DATA_W-1:0] writeData,
	input wire logic [wpr_pkg::WPR_BE_W-1:0] byteEn,
	// Read port.
	output logic [wpr_pkg::WPR_DATA_W-1:0] readWord
);
	import wpr_pkg::*;

	logic [WORDS-1:0][WPR_DATA_W-1:0] mem;

	// A locked write is dropped without any error or flag.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mem <= '0;
		end else if (writeEn && unlock) begin
			for (int b = 0; b < WPR_BE_W; b++) begin
				if (byteEn[b]) begin
					mem[wordIdx][b*8 +: 8] <= writeData[b*8 +: 8];
				end
			end
		end
	end

	always_comb begin
		readWord = WPR_UNMAPPED_READ;
		if (int'(wordIdx) < WORDS) begin
			readWord = mem[wordIdx];
		end
	end

	AST_BANK_LOCKED_HOLDS: assert property (@(posedge clk_sys) disable iff (!rst_b)
		writeEn && !unlock |=> $stable(mem))
		else $error("Locked bank changed on a write.");

	AST_BANK_UNLOCKED_LOADS: assert property (@(posedge clk_sys) disable iff (!rst_b)
		writeEn && unlock && byteEn == 4'hF |=> mem[$past(wordIdx)] == $past(writeData))
		else $error("Unlocked bank ignored a full-word write.");

endmodule : wpr_prot_bank

// ==== hdl/wpr_register_write_protection.sv ====
// Register write protection unit with its protected groups behind an Avalon-MM slave.
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns

module wpr_register_write_protection (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_b,
	// Avalon-MM slave.
	input wire logic [wpr_pkg::WPR_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [wpr_pkg::WPR_DATA_W-1:0] avs_writedata,
	input wire logic [wpr_pkg::WPR_BE_W-1:0] avs_byteenable,
	output logic [wpr_pkg::WPR_DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	// Lock state and software reset request.
	output logic clockRegsUnlock,
	output logic modePowerRegsUnlock,
	output logic voltageMonitorRegsUnlock,
	output logic softwareResetReq
);
	import wpr_pkg::*;

	logic accept;
	logic ctrlHit;
	logic clkHit;
	logic modeHit;
	logic vmonHit;
	logic keyOk;
	logic ctrlWrite;
	logic [1:0] wordIdx;
	logic [WPR_DATA_W-1:0] rdWord;
	logic [WPR_DATA_W-1:0] ctrlWord;
	logic [WPR_DATA_W-1:0] clkWord;
	logic [WPR_DATA_W-1:0] modeWord;
	logic [WPR_DATA_W-1:0] vmonWord;
	logic clockRegsUnlock_q;
	logic modePowerRegsUnlock_q;
	logic voltageMonitorRegsUnlock_q;
	logic softwareResetReq_q;
	logic firstAfterReset_q;

	wpr_avalon_slave uSlave (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.rdWord(rdWord),
		.avs_waitrequest(avs_waitrequest),
		.avs_readdata(avs_readdata),
		.accept(accept)
	);

	// Address decode; each group owns a 16-byte window and only its populated words.
	assign wordIdx = avs_address[3:2];
	assign ctrlHit = avs_address == WPR_ADDR_CTRL;
	assign clkHit = avs_address[7:4] == WPR_ADDR_CLK_BASE[7:4] && avs_address[1:0] == 2'h0
		&& {1'b0, wordIdx} < WPR_CLK_WORDS;
	assign modeHit = avs_address[7:4] == WPR_ADDR_MODE_BASE[7:4] && avs_address[1:0] == 2'h0
		&& {1'b0, wordIdx} < WPR_MODE_WORDS;
	assign vmonHit = avs_address[7:4] == WPR_ADDR_VMON_BASE[7:4] && avs_address[1:0] == 2'h0
		&& {1'b0, wordIdx} < WPR_VMON_WORDS;

	// The key byte and the lock-bit byte must both be enabled, so a lone low-byte write can never carry the key.
	assign keyOk = avs_byteenable[1:0] == 2'b11
		&& avs_writedata[WPR_KEY_MSB:WPR_KEY_LSB] == WPR_UNLOCK_KEY;
	assign ctrlWrite = accept && avs_write && ctrlHit;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			clockRegsUnlock_q <= WPR_LOCK_RESET;
			modePowerRegsUnlock_q <= WPR_LOCK_RESET;
			voltageMonitorRegsUnlock_q <= WPR_LOCK_RESET;
		end else if (ctrlWrite && keyOk) begin
			clockRegsUnlock_q <= avs_writedata[WPR_LOCK_CLK_BIT];
			modePowerRegsUnlock_q <= avs_writedata[WPR_LOCK_MODE_BIT];
			voltageMonitorRegsUnlock_q <= avs_writedata[WPR_LOCK_VMON_BIT];
		end
	end

	wpr_prot_bank #(
		.WORDS(int'(WPR_CLK_WORDS))
	) uClkBank (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.writeEn(accept && avs_write && clkHit),
		.unlock(clockRegsUnlock_q),
		.wordIdx(wordIdx),
		.writeData(avs_writedata),
		.byteEn(avs_byteenable),
		.readWord(clkWord)
	);

	wpr_prot_bank #(
		.WORDS(int'(WPR_MODE_WORDS))
	) uModeBank (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.writeEn(accept && avs_write && modeHit),
		.unlock(modePowerRegsUnlock_q),
		.wordIdx(wordIdx),
		.writeData(avs_writedata),
		.byteEn(avs_byteenable),
		.readWord(modeWord)
	);

	wpr_prot_bank #(
		.WORDS(int'(WPR_VMON_WORDS))
	) uVmonBank (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.writeEn(accept && avs_write && vmonHit),
		.unlock(voltageMonitorRegsUnlock_q),
		.wordIdx(wordIdx),
		.writeData(avs_writedata),
		.byteEn(avs_byteenable),
		.readWord(vmonWord)
	);

	// A permitted write to the software reset word raises a one-cycle request.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			softwareResetReq_q <= 1'b0;
		end else begin
			softwareResetReq_q <= accept && avs_write && modeHit && wordIdx == WPR_SWRST_IDX
				&& modePowerRegsUnlock_q;
		end
	end

	// Key and reserved positions are never stored, so they read back as zero.
	always_comb begin
		ctrlWord = WPR_REG_RESET;
		ctrlWord[WPR_LOCK_CLK_BIT] = clockRegsUnlock_q;
		ctrlWord[WPR_LOCK_MODE_BIT] = modePowerRegsUnlock_q;
		ctrlWord[WPR_LOCK_VMON_BIT] = voltageMonitorRegsUnlock_q;
	end

	always_comb begin
		rdWord = WPR_UNMAPPED_READ;
		if (ctrlHit) begin
			rdWord = ctrlWord;
		end else if (clkHit) begin
			rdWord = clkWord;
		end else if (modeHit) begin
			rdWord = modeWord;
		end else if (vmonHit) begin
			rdWord = vmonWord;
		end
	end

	assign clockRegsUnlock = clockRegsUnlock_q;
	assign modePowerRegsUnlock = modePowerRegsUnlock_q;
	assign voltageMonitorRegsUnlock = voltageMonitorRegsUnlock_q;
	assign softwareResetReq = softwareResetReq_q;

	// Helper for checking the state seen at the first edge after reset.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			firstAfterReset_q <= 1'b1;
		end else begin
			firstAfterReset_q <= 1'b0;
		end
	end

	default clocking cbSys @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	sequence sCtrlKeyWrite;
		ctrlWrite && keyOk;
	endsequence

	sequence sUnlockAll;
		ctrlWrite && avs_byteenable[1:0] == 2'b11 && avs_writedata[15:0] == WPR_UNLOCK_ALL;
	endsequence

	sequence sLockAll;
		ctrlWrite && avs_byteenable[1:0] == 2'b11 && avs_writedata[15:0] == WPR_LOCK_ALL;
	endsequence

	sequence sCtrlReadTaken;
		avs_read && avs_waitrequest && ctrlHit;
	endsequence

	AST_KEYLESS_WRITE_HOLDS: assert property (
		ctrlWrite && !keyOk |=> $stable({clockRegsUnlock_q, modePowerRegsUnlock_q,
			voltageMonitorRegsUnlock_q}))
		else $error("Lock bits changed without the key.");

	AST_KEYED_WRITE_LOADS: assert property (
		sCtrlKeyWrite |=> clockRegsUnlock_q == $past(avs_writedata[0])
			&& modePowerRegsUnlock_q == $past(avs_writedata[1])
			&& voltageMonitorRegsUnlock_q == $past(avs_writedata[3]))
		else $error("Keyed write did not load the lock bits.");

	AST_RESET_LOCKED: assert property (
		firstAfterReset_q |-> !clockRegsUnlock_q && !modePowerRegsUnlock_q
			&& !voltageMonitorRegsUnlock_q)
		else $error("A lock bit was set right after reset.");

	AST_UNLOCK_ALL: assert property (
		sUnlockAll |=> clockRegsUnlock_q && modePowerRegsUnlock_q && voltageMonitorRegsUnlock_q)
		else $error("Unlock-all write left a group protected.");

	AST_LOCK_ALL: assert property (
		sLockAll |=> !clockRegsUnlock_q && !modePowerRegsUnlock_q && !voltageMonitorRegsUnlock_q)
		else $error("Lock-all write left a group open.");

	AST_CLK_GROUP_GUARD: assert property (
		accept && avs_write && clkHit && !clockRegsUnlock_q |=> $stable(uClkBank.mem))
		else $error("Clock group changed while locked.");

	AST_MODE_GROUP_GUARD: assert property (
		accept && avs_write && modeHit && !modePowerRegsUnlock_q
			|=> $stable(uModeBank.mem) && !softwareResetReq_q)
		else $error("Mode group changed or reset requested while locked.");

	AST_VMON_GROUP_GUARD: assert property (
		accept && avs_write && vmonHit && !voltageMonitorRegsUnlock_q |=> $stable(uVmonBank.mem))
		else $error("Voltage monitor group changed while locked.");

	AST_CTRL_READBACK: assert property (
		sCtrlReadTaken |=> avs_readdata == {28'h000_0000, $past(voltageMonitorRegsUnlock_q), 1'b0,
			$past(modePowerRegsUnlock_q), $past(clockRegsUnlock_q)})
		else $error("Control readback wrong.");

	AST_ONE_WAIT_CYCLE: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("Bus answer did not come after exactly one wait cycle.");

	sequence sLockedGroupWrite;
		accept && avs_write && ((clkHit && !clockRegsUnlock_q)
			|| (modeHit && !modePowerRegsUnlock_q)
			|| (vmonHit && !voltageMonitorRegsUnlock_q));
	endsequence

	sequence sSwrstWordWrite;
		accept && avs_write
			&& avs_address == (WPR_ADDR_MODE_BASE | {4'h0, WPR_SWRST_IDX, 2'h0});
	endsequence

	sequence sShortCtrlWrite;
		ctrlWrite && avs_byteenable[1:0] != 2'b11;
	endsequence

	// Catches a lock bit that moves from any source, not only from the control path.
	AST_LOCKS_ONLY_BY_KEY: assert property (
		!$stable({clockRegsUnlock_q, modePowerRegsUnlock_q, voltageMonitorRegsUnlock_q})
			|-> $past(ctrlWrite && keyOk))
		else $error("A lock bit changed without a keyed control write.");

	AST_HALF_WORD_KEY_ONLY: assert property (
		sShortCtrlWrite |=> $stable({clockRegsUnlock_q, modePowerRegsUnlock_q,
			voltageMonitorRegsUnlock_q}))
		else $error("Lock bits changed on a control write narrower than 16 bits.");

	AST_LOCKED_WRITE_SILENT: assert property (
		sLockedGroupWrite |=> avs_waitrequest && !softwareResetReq_q
			&& $stable({clockRegsUnlock_q, modePowerRegsUnlock_q,
			voltageMonitorRegsUnlock_q}))
		else $error("A locked write left a trace beyond being dropped.");

	AST_SWRST_FOLLOWS_LOCK: assert property (
		sSwrstWordWrite |=> softwareResetReq_q == $past(modePowerRegsUnlock_q))
		else $error("Software reset request did not follow its lock bit.");

	AST_SWRST_HAS_CAUSE: assert property (
		softwareResetReq_q |-> $past(accept && avs_write && modePowerRegsUnlock_q)
			&& $past(avs_address) == (WPR_ADDR_MODE_BASE | {4'h0, WPR_SWRST_IDX, 2'h0}))
		else $error("Software reset request raised without a permitted write.");

	AST_SWRST_ONE_CYCLE: assert property (
		softwareResetReq_q |=> !softwareResetReq_q)
		else $error("Software reset request stood longer than one cycle.");

	// A mis-wired lock bit would slip past the guards above, so each group is shown to open.
	AST_CLK_OPEN_LOADS: assert property (
		accept && avs_write && clkHit && avs_byteenable == 4'hF && clockRegsUnlock_q
			|=> uClkBank.mem[$past(wordIdx)] == $past(avs_writedata))
		else $error("Open clock group ignored a full-word write.");

	AST_MODE_OPEN_LOADS: assert property (
		accept && avs_write && modeHit && avs_byteenable == 4'hF && modePowerRegsUnlock_q
			|=> uModeBank.mem[$past(wordIdx)] == $past(avs_writedata))
		else $error("Open mode group ignored a full-word write.");

	AST_VMON_OPEN_LOADS: assert property (
		accept && avs_write && vmonHit && avs_byteenable == 4'hF && voltageMonitorRegsUnlock_q
			|=> uVmonBank.mem[$past(wordIdx)] == $past(avs_writedata))
		else $error("Open voltage monitor group ignored a full-word write.");

	AST_RESET_BUS_IDLE: assert property (
		firstAfterReset_q |-> avs_waitrequest && !softwareResetReq_q
			&& avs_readdata == WPR_REG_RESET)
		else $error("Bus side not idle right after reset.");

	AST_RESET_BANKS_CLEAR: assert property (
		firstAfterReset_q |-> uClkBank.mem == '0 && uModeBank.mem == '0
			&& uVmonBank.mem == '0)
		else $error("A protected group held data right after reset.");

endmodule : wpr_register_write_protection

// ==== verif/wpr_tb.sv ====
// Self-checking testbench for the register write protection block.
`timescale 1ns/1ns
module tb;
	import wpr_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic clockRegsUnlock;
	logic modePowerRegsUnlock;
	logic voltageMonitorRegsUnlock;
	logic softwareResetReq;
	int fail_count = 0;
	int num_checks = 0;
	logic [31:0] mdl [16];
	logic [3:0] lockMdl;
	logic [31:0] rd;

	always #25 clk_sys = ~clk_sys;

	wpr_register_write_protection dut (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.clockRegsUnlock(clockRegsUnlock),
		.modePowerRegsUnlock(modePowerRegsUnlock),
		.voltageMonitorRegsUnlock(voltageMonitorRegsUnlock),
		.softwareResetReq(softwareResetReq)
	);

	task automatic close_out;
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// The request is held until waitrequest is sampled low; a hang is left to the watchdog.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge clk_sys);
		avs_read <= ~wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		#1;
	endtask : bus

	function automatic logic grpOpen(input int w);
		return w < 8 ? lockMdl[0] : (w < 12 ? lockMdl[1] : lockMdl[3]);
	endfunction : grpOpen

	// Upper half is driven with ones so that a design decoding it would show up.
	task automatic wrCtrl(input logic [15:0] v, input logic [3:0] be);
		bus(1'b1, WPR_ADDR_CTRL, {16'hFFFF, v}, be);
		if (be[1:0] == 2'b11 && v[15:8] == WPR_UNLOCK_KEY) begin
			lockMdl = v[3:0] & 4'hB;
		end
		chk({voltageMonitorRegsUnlock, modePowerRegsUnlock, clockRegsUnlock},
			{lockMdl[3], lockMdl[1], lockMdl[0]});
		bus(1'b0, WPR_ADDR_CTRL, 32'h0000_0000, 4'hF);
		chk(rd, 32'(lockMdl));
	endtask : wrCtrl

	task automatic wrWord(input int w, input logic [31:0] d, input logic [3:0] be);
		bus(1'b1, 8'(w * 4), d, be);
		chk(32'(softwareResetReq), 32'(w == 11 && grpOpen(w)));
		if (w < 14 && grpOpen(w)) begin
			for (int b = 0; b < 4; b++) begin
				if (be[b]) begin
					mdl[w][8*b +: 8] = d[8*b +: 8];
				end
			end
		end
		bus(1'b0, 8'(w * 4), 32'h0000_0000, 4'hF);
		chk(rd, w < 14 ? mdl[w] : WPR_UNMAPPED_READ);
	endtask : wrWord

	task automatic doReset;
		@(posedge clk_sys);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		foreach (mdl[i]) begin
			mdl[i] = WPR_REG_RESET;
		end
		lockMdl = 4'h0;
	endtask : doReset

	initial begin
		void'($urandom(36523));
		doReset();
		wrCtrl(16'h0000, 4'hF);
		for (int w = 4; w < 16; w++) begin
			wrWord(w, $urandom, 4'hF);
		end
		wrCtrl(16'h5A0B, 4'h3);
		wrCtrl(16'hA50B, 4'h1);
		wrCtrl(WPR_UNLOCK_ALL, 4'h3);
		for (int w = 4; w < 16; w++) begin
			wrWord(w, $urandom, 4'($urandom));
		end
		wrCtrl(WPR_LOCK_ALL, 4'hF);
		wrWord(11, $urandom, 4'hF);
		for (int i = 0; i < 80; i++) begin
			if ($urandom_range(2) == 0) begin
				wrCtrl({($urandom_range(3) == 0) ? 8'($urandom) : WPR_UNLOCK_KEY,
					8'($urandom)}, 4'hF);
			end else begin
				wrWord(4 + $urandom_range(9), $urandom, 4'($urandom));
			end
		end
		bus(1'b0, 8'h40, 32'h0000_0000, 4'hF);
		chk(rd, WPR_UNMAPPED_READ);
		wrCtrl(WPR_UNLOCK_ALL, 4'hF);
		wrWord(5, 32'hDEAD_BEEF, 4'hF);
		doReset();
		wrCtrl(16'h0000, 4'hF);
		wrWord(5, 32'h1234_5678, 4'hF);
		close_out();
	end

	// Roughly 230 transfers of under ten cycles each fit well inside this span.
	initial begin
		#1_000_000;
		fail_count++;
		close_out();
	end
endmodule : tb
